// ==== hdl/dfl_consts.vh ====
// Constants for the DPLL frequency lock and phase step monitor
`ifndef DFL_CONSTS_VH
`define DFL_CONSTS_VH
`define DFL_ADDR_W 12
`define DFL_OFS_FTHR 12'h000
`define DFL_OFS_STHR 12'h020
`define DFL_OFS_RATE 12'h040
`define DFL_OFS_CTRL 12'h060
`define DFL_OFS_STAT 12'h064
`define DFL_OFS_END 12'h068
`define DFL_FTHR_RST 24'h000000
`define DFL_STHR_RST 32'h00000000
`define DFL_FILL_RST 8'h01
`define DFL_DRAIN_RST 8'h01
`define DFL_CTRL_RST 2'h0
`define DFL_ST_LOCK 0
`define DFL_ST_STEP 1
`define DFL_ST_SLOCK 2
`define DFL_ST_SUNLK 3
`define DFL_ST_SSTEP 4
`define DFL_ST_STRIDE 8
`define DFL_LVL_MIN 14'sh3800
`define DFL_LVL_MAX 14'sh07ff
`define DFL_LVL_LOW 14'sh3bff
`define DFL_LVL_HIGH 14'sh0400
`endif

// ==== hdl/dfl_lock_bucket.v ====
// Leaky bucket frequency lock detector for one DPLL channel
`include "dfl_consts.vh"
`default_nettype none
module dfl_lock_bucket (
	input wire clk,
	input wire rstn,
	input wire sampleStb,
	input wire fillReq,
	input wire [7:0] fillRate,
	input wire [7:0] drainRate,
	output reg locked_q
);
	reg signed [13:0] level_q;
	reg signed [13:0] level_d;
	reg signed [13:0] sum;
	always @* begin
		// One fill or one drain per sample, never both
		if (fillReq) begin
			sum = level_q + $signed({6'h00, fillRate});
		end else begin
			sum = level_q - $signed({6'h00, drainRate});
		end
		// Saturate within -2048..+2047
		if (sum > `DFL_LVL_MAX) begin
			level_d = `DFL_LVL_MAX;
		end else if (sum < `DFL_LVL_MIN) begin
			level_d = `DFL_LVL_MIN;
		end else begin
			level_d = sum;
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level_q <= `DFL_LVL_MIN;
			locked_q <= 1'b0;
		end else if (sampleStb) begin
			level_q <= level_d;
			// Hysteresis between the low and high marks
			if (level_d > `DFL_LVL_HIGH) begin
				locked_q <= 1'b1;
			end else if (level_d < `DFL_LVL_LOW) begin
				locked_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/dfl_monitor.v ====
// DPLL frequency lock detector and phase step detector with APB registers
`include "dfl_consts.vh"
`default_nettype none
module dfl_monitor #(
	parameter NCH = 2,
	parameter NPROF = 8
) (
	input wire clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`DFL_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [NCH-1:0] periodStb,
	input wire [NCH*32-1:0] refPeriod,
	input wire [NCH*32-1:0] fbPeriod,
	input wire [NCH-1:0] phaseStb,
	input wire [NCH*32-1:0] phaseErr,
	input wire [NCH*3-1:0] profileSel,
	output wire [NCH-1:0] freqLocked,
	output reg [NCH-1:0] stepLive_q,
	output reg [NCH-1:0] acqRestart_q,
	output reg [NCH-1:0] refMonReset_q
);
	reg [23:0] freqThr_q [0:NPROF-1];
	reg [31:0] stepThr_q [0:NPROF-1];
	reg [7:0] fillRate_q [0:NPROF-1];
	reg [7:0] drainRate_q [0:NPROF-1];
	reg [NCH-1:0] stepFaultEn_q;
	reg [NCH-1:0] lockPrev_q;
	reg [NCH-1:0] stickyLock_q;
	reg [NCH-1:0] stickyUnlock_q;
	reg [NCH-1:0] stickyStep_q;
	wire [NCH-1:0] stepEvent;
	wire [NCH-1:0] stepOver;
	wire [NCH-1:0] lockRise;
	wire [NCH-1:0] lockFall;
	wire [NCH-1:0] clrLock;
	wire [NCH-1:0] clrUnlock;
	wire [NCH-1:0] clrStep;
	wire setup;
	wire wrDone;
	wire [3:0] regIdx;
	reg [31:0] rdData;
	reg rdErr;
	integer p;
	integer c;
	integer s;

	assign setup = psel & ~penable & ~pready;
	assign wrDone = psel & penable & pready & pwrite & ~pslverr;
	assign regIdx = paddr[5:2];

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gCh
			wire [2:0] prof;
			wire signed [32:0] perDiff;
			wire [32:0] perMag;
			wire signed [32:0] phs;
			wire [32:0] phsMag;
			wire [31:0] sThr;
			assign prof = profileSel[g*3 +: 3];
			// Period deviation, not phase error, drives the bucket
			assign perDiff = $signed({1'b0, refPeriod[g*32 +: 32]}) -
				$signed({1'b0, fbPeriod[g*32 +: 32]});
			assign perMag = perDiff[32] ? (33'h000000000 - perDiff) : perDiff;
			assign phs = $signed({phaseErr[g*32+31], phaseErr[g*32 +: 32]});
			assign phsMag = phs[32] ? (33'h000000000 - phs) : phs;
			assign sThr = stepThr_q[prof];
			// Zero threshold disables; nonzero enables
			assign stepOver[g] = (sThr != 32'h00000000) & (phsMag > {1'b0, sThr});
			// Armed only while frequency locked, every phase sample
			assign stepEvent[g] = phaseStb[g] & freqLocked[g] & stepOver[g];
			assign lockRise[g] = freqLocked[g] & ~lockPrev_q[g];
			assign lockFall[g] = ~freqLocked[g] & lockPrev_q[g];
			assign clrLock[g] = wrDone & (paddr == `DFL_OFS_STAT) &
				pwdata[g*`DFL_ST_STRIDE + `DFL_ST_SLOCK];
			assign clrUnlock[g] = wrDone & (paddr == `DFL_OFS_STAT) &
				pwdata[g*`DFL_ST_STRIDE + `DFL_ST_SUNLK];
			assign clrStep[g] = wrDone & (paddr == `DFL_OFS_STAT) &
				pwdata[g*`DFL_ST_STRIDE + `DFL_ST_SSTEP];
			// Magnitude within 24-bit threshold fills
			dfl_lock_bucket uBucket (
				.clk(clk),
				.rstn(rstn),
				.sampleStb(periodStb[g]),
				.fillReq(perMag <= {9'h000, freqThr_q[prof]}),
				.fillRate(fillRate_q[prof]),
				.drainRate(drainRate_q[prof]),
				.locked_q(freqLocked[g])
			);
		end
	endgenerate

	// Per-channel status, sticky flags and step actions
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lockPrev_q <= {NCH{1'b0}};
			stickyLock_q <= {NCH{1'b0}};
			stickyUnlock_q <= {NCH{1'b0}};
			stickyStep_q <= {NCH{1'b0}};
			stepLive_q <= {NCH{1'b0}};
			acqRestart_q <= {NCH{1'b0}};
			refMonReset_q <= {NCH{1'b0}};
		end else begin
			lockPrev_q <= freqLocked;
			// Set wins over clear; live bits untouched by clear
			stickyLock_q <= lockRise | (stickyLock_q & ~clrLock);
			stickyUnlock_q <= lockFall | (stickyUnlock_q & ~clrUnlock);
			stickyStep_q <= stepEvent | (stickyStep_q & ~clrStep);
			for (c = 0; c < NCH; c = c + 1) begin
				// Live step status follows the latest phase sample while frequency locked; held clear while unlocked
				if (!freqLocked[c]) begin
					stepLive_q[c] <= 1'b0;
				end else if (phaseStb[c]) begin
					stepLive_q[c] <= stepOver[c];
				end
			end
			// Restart pulse hands the step to acquisition control
			acqRestart_q <= stepEvent;
			// Monitor reset only with the fault enable set
			refMonReset_q <= stepEvent & stepFaultEn_q;
		end
	end

	// Register writes
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (p = 0; p < NPROF; p = p + 1) begin
				freqThr_q[p] <= `DFL_FTHR_RST;
				stepThr_q[p] <= `DFL_STHR_RST;
				fillRate_q[p] <= `DFL_FILL_RST;
				drainRate_q[p] <= `DFL_DRAIN_RST;
			end
			stepFaultEn_q <= `DFL_CTRL_RST;
		end else if (wrDone) begin
			if (paddr < `DFL_OFS_STHR) begin
				freqThr_q[regIdx[2:0]] <= pwdata[23:0];
			end else if (paddr < `DFL_OFS_RATE) begin
				stepThr_q[regIdx[2:0]] <= pwdata;
			end else if (paddr < `DFL_OFS_CTRL) begin
				fillRate_q[regIdx[2:0]] <= pwdata[7:0];
				drainRate_q[regIdx[2:0]] <= pwdata[15:8];
			end else if (paddr == `DFL_OFS_CTRL) begin
				stepFaultEn_q <= pwdata[NCH-1:0];
			end
		end
	end

	// Read mux and decode
	always @* begin
		rdData = 32'h00000000;
		rdErr = 1'b0;
		if (paddr[1:0] != 2'h0 || paddr >= `DFL_OFS_END) begin
			rdErr = 1'b1;
		end else if (paddr < `DFL_OFS_STHR) begin
			rdData = {8'h00, freqThr_q[regIdx[2:0]]};
		end else if (paddr < `DFL_OFS_RATE) begin
			rdData = stepThr_q[regIdx[2:0]];
		end else if (paddr < `DFL_OFS_CTRL) begin
			rdData = {16'h0000, drainRate_q[regIdx[2:0]], fillRate_q[regIdx[2:0]]};
		end else if (paddr == `DFL_OFS_CTRL) begin
			rdData[NCH-1:0] = stepFaultEn_q;
		end else begin
			for (s = 0; s < NCH; s = s + 1) begin
				rdData[s*`DFL_ST_STRIDE + `DFL_ST_LOCK] = freqLocked[s];
				rdData[s*`DFL_ST_STRIDE + `DFL_ST_STEP] = stepLive_q[s];
				rdData[s*`DFL_ST_STRIDE + `DFL_ST_SLOCK] = stickyLock_q[s];
				rdData[s*`DFL_ST_STRIDE + `DFL_ST_SUNLK] = stickyUnlock_q[s];
				rdData[s*`DFL_ST_STRIDE + `DFL_ST_SSTEP] = stickyStep_q[s];
			end
		end
	end

	// APB slave: one access cycle, answer prepared in the setup cycle
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= rdErr;
			prdata <= pwrite ? 32'h00000000 : rdData;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== verification/dfl_checker.sv ====
// Assertion checker for the DPLL lock and step monitor
`default_nettype none
module dfl_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] periodStb,
	input wire logic [1:0] phaseStb,
	input wire logic [1:0] freqLocked,
	input wire logic [1:0] stepLive_q,
	input wire logic [1:0] acqRestart_q,
	input wire logic [1:0] refMonReset_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence setupSeq; psel && !penable; endsequence
	sequence accessSeq; psel && penable && pready; endsequence
	apb_answer_a: assert property (setupSeq |=> accessSeq) else $error("no apb answer");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	bad_addr_a: assert property (pready && (paddr >= 12'h068 || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("pslverr missing");
	good_addr_a: assert property (pready && paddr < 12'h068 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("pslverr spurious");
	lock_cause_a: assert property ($changed(freqLocked[0]) |-> $past(periodStb[0]))
		else $error("lock moved without sample");
	step_locked_a: assert property (acqRestart_q[0] |-> $past(phaseStb[0] && freqLocked[0]))
		else $error("restart without locked step");
	mon_pair_a: assert property ((refMonReset_q & ~acqRestart_q) == 2'h0)
		else $error("monitor reset alone");
	live_step_a: assert property ($rose(stepLive_q[0]) |-> acqRestart_q[0])
		else $error("live step without restart");
endmodule
bind dfl_monitor dfl_checker chk_u (.*);
`default_nettype wire

// ==== verification/dfl_pd_model.sv ====
// Behavioural phase detector supplying period and phase samples
`default_nettype none
module dfl_pd_model (
	input wire logic clk,
	output var logic [1:0] periodStb,
	output var logic [63:0] refPeriod,
	output var logic [63:0] fbPeriod,
	output var logic [1:0] phaseStb,
	output var logic [63:0] phaseErr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		periodStb = 2'h0;
		phaseStb = 2'h0;
		refPeriod = 64'h0;
		fbPeriod = 64'h0;
		phaseErr = 64'h0;
	end
	// Sample values are scrambled once the strobe drops
	task automatic sendPeriod(input logic [31:0] r, input logic [31:0] f, input int n);
		repeat (n) begin
			@(posedge clk);
			periodStb <= 2'h1;
			refPeriod[31:0] <= r;
			fbPeriod[31:0] <= f;
			@(posedge clk);
			periodStb <= 2'h0;
			refPeriod <= ~refPeriod;
			fbPeriod <= ~fbPeriod;
		end
	endtask
	task automatic sendPhase(input logic [31:0] e);
		@(posedge clk);
		phaseStb <= 2'h1;
		phaseErr[31:0] <= e;
		@(posedge clk);
		phaseStb <= 2'h0;
		phaseErr <= ~phaseErr;
	endtask
endmodule
`default_nettype wire

// ==== verification/dfl_tb_top.sv ====
// Self-checking bench for the DPLL lock and step monitor
`default_nettype none
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, errQ;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdQ;
	logic [1:0] perStb, phStb, locked, stepLive, restart, monReset;
	logic [5:0] profSel;
	logic [63:0] refP, fbP, phErr;
	int errors, tests_run, cyc;
	dfl_monitor dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periodStb(perStb), .refPeriod(refP), .fbPeriod(fbP), .phaseStb(phStb),
		.phaseErr(phErr), .profileSel(profSel), .freqLocked(locked), .stepLive_q(stepLive),
		.acqRestart_q(restart), .refMonReset_q(monReset));
	dfl_pd_model pd_u (.clk(clk), .periodStb(perStb), .refPeriod(refP), .fbPeriod(fbP),
		.phaseStb(phStb), .phaseErr(phErr));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			conclude();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdQ = prdata;
		errQ = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CK(rdQ, e)
	endtask
	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		profSel = 6'h00;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(12'h060, 32'h0);
		rd(12'h020, 32'h0);
		rd(12'h040, 32'h0101);
		rd(12'h06c, 32'h0);
		`CK(errQ, 1'b1)
		$display("test reset done");
		apb(1'b1, 12'h000, 32'h64);
		apb(1'b1, 12'h040, 32'h8080);
		pd_u.sendPeriod(32'd1000, 32'd1100, 24);
		#1 `CK(locked, 2'h0)
		pd_u.sendPeriod(32'd1000, 32'd1100, 1);
		#1 `CK(locked, 2'h1)
		rd(12'h064, 32'h05);
		apb(1'b1, 12'h064, 32'h1c);
		rd(12'h064, 32'h01);
		pd_u.sendPhase(32'd10000);
		#1 `CK(restart, 2'h0)
		pd_u.sendPeriod(32'd1000, 32'd1100, 10);
		pd_u.sendPeriod(32'd1101, 32'd1000, 24);
		#1 `CK(locked, 2'h1)
		pd_u.sendPeriod(32'd1101, 32'd1000, 1);
		#1 `CK(locked, 2'h0)
		rd(12'h064, 32'h08);
		$display("test lock done");
		apb(1'b1, 12'h020, 32'd500);
		pd_u.sendPhase(32'd10000);
		#1 `CK(restart, 2'h0)
		pd_u.sendPeriod(32'd1000, 32'd1000, 25);
		pd_u.sendPhase(-32'sd501);
		#1 `CK({monReset, stepLive, restart}, 6'h05)
		pd_u.sendPhase(32'd500);
		#1 `CK({stepLive, restart}, 4'h0)
		rd(12'h064, 32'h1d);
		apb(1'b1, 12'h060, 32'h1);
		pd_u.sendPhase(32'd501);
		#1 `CK({monReset, restart}, 4'h5)
		profSel <= 6'h01;
		pd_u.sendPhase(32'd10000);
		#1 `CK({monReset, restart}, 4'h0)
		$display("test step done");
		conclude();
	end
endmodule
`default_nettype wire
